// >>> logic/fpu_regs.vh
`ifndef FPU_REGS_VH
`define FPU_REGS_VH
// AXI register word indices (address bits 5:2)
`define FPU_ADDR_CTRL   4'h0
`define FPU_ADDR_CMD    4'h1
`define FPU_ADDR_FLAGS  4'h2
`define FPU_ADDR_ACCUM  4'h3
`define FPU_ADDR_PORT   4'h4
`define FPU_ADDR_STACKP 4'h5
`define FPU_ADDR_INDEX  4'h6
`define FPU_ADDR_STATUS 4'h7
`define FPU_ADDR_STKTOP 4'h8
`define FPU_ADDR_IODATA 4'h9
// Command opcodes
`define FPU_OP_SETC     5'h01
`define FPU_OP_CLRC     5'h02
`define FPU_OP_INVC     5'h03
`define FPU_OP_CLRD     5'h04
`define FPU_OP_SETD     5'h05
`define FPU_OP_F2H      5'h06
`define FPU_OP_H2F      5'h07
`define FPU_OP_FLAGS_PUSH_OP    5'h08
`define FPU_OP_FLAGS_POP_OP     5'h09
`define FPU_OP_INTERRUPT_RETURN_OP     5'h0a
`define FPU_OP_PADD     5'h0b
`define FPU_OP_PSUB     5'h0c
`define FPU_OP_UADD     5'h0d
`define FPU_OP_USUB     5'h0e
`define FPU_OP_UMUL     5'h0f
`define FPU_OP_UDIV     5'h10
`define FPU_OP_MASKI    5'h11
`define FPU_OP_UNMASKI  5'h12
`define FPU_OP_HALT     5'h13
`define FPU_OP_LOCK     5'h14
`define FPU_OP_IN_IMM   5'h15
`define FPU_OP_IN_REG   5'h16
`define FPU_OP_OUT_IMM  5'h17
`define FPU_OP_OUT_REG  5'h18
`define FPU_OP_STRING   5'h19
// Flag word bit positions
`define FPU_F_CARRY     0
`define FPU_F_PARITY    2
`define FPU_F_AUX       4
`define FPU_F_ZERO      6
`define FPU_F_SIGN      7
`define FPU_F_IE        9
`define FPU_F_DIR       10
`define FPU_F_IO_PRIVILEGE_FIELD_LO   12
`define FPU_F_IO_PRIVILEGE_FIELD_HI   13
`define FPU_FLAGS_RST   16'h0002
`define FPU_FLAGS_VALID 16'h3ed5
`define FPU_STEP        16'h0001
`define FPU_STACK_STEP  16'h0002
`define FPU_NIB_MAX     4'h9
`define FPU_DEC_ADJ     8'h06
`define FPU_DEC_ADJ_HI  8'h60
`define FPU_PK_MAX      8'h99
`define FPU_LOW_NIB     8'h0f
`define FPU_TEN         8'h0a
`define FPU_AXI_OKAY    2'b00
`define FPU_AXI_SLVERR  2'b10
`endif

// >>> logic/fpu_unit.v
`include "fpu_regs.vh"
`default_nettype none
module fpu_unit #(
  parameter IDX_W = 16
) (
  // Clock and reset
  input  wire        clock,
  input  wire        reset,
  // AXI4-Lite write
  input  wire [31:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read
  input  wire [31:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // Peripheral ports
  output reg  [15:0] io_addr,
  output reg  [15:0] io_wdata,
  output reg         io_wide,
  output reg         io_read,
  output reg         io_write,
  input  wire [15:0] io_rdata,
  // Stack memory
  output reg  [15:0] stack_addr,
  output reg  [15:0] stack_wdata,
  output reg         stack_write,
  // Core status
  output reg         bus_lock,
  output reg         halted,
  output reg         protection_fault,
  input  wire        irq_maskable,
  input  wire        irq_nonmaskable,
  output reg         irq_take
);
  reg [15:0]      flags;
  reg [15:0]      accumulator_word;
  reg [15:0]      port_number_register;
  reg [15:0]      stack_pointer;
  reg [IDX_W-1:0] source_index;
  reg [IDX_W-1:0] destination_index;
  reg [15:0]      stack_top;
  reg [1:0]       current_privilege;
  reg             protected_mode;
  reg [7:0]       port_imm;
  reg             lock_pending;
  reg [15:0]      io_data;
  reg             aw_held;
  reg             w_held;
  reg [31:0]      aw_addr;
  reg [31:0]      w_data;
  reg [15:0]      next_flags;
  reg [15:0]      next_acc;
  reg [15:0]      next_sp;
  reg             next_fault;
  reg             priv_ok;
  reg             cmd_go;
  reg [4:0]       cmd_op;
  reg             cmd_wide;
  reg [7:0]       al;
  reg [7:0]       ah;
  reg [7:0]       t8;
  reg             dc;
  reg [15:0]      popped;
  reg [15:0]      prod;
  wire [1:0] io_privilege_field = flags[`FPU_F_IO_PRIVILEGE_FIELD_HI:`FPU_F_IO_PRIVILEGE_FIELD_LO];
  // Only held halves fire, so a command runs once per write
  wire       wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire [31:0] wa = aw_addr;
  wire [31:0] wd = w_data;
  wire [3:0]  widx = wa[5:2];

  // Instruction execution, one command per write to the command register
  always @* begin
    next_flags = flags;
    next_acc   = accumulator_word;
    next_sp    = stack_pointer;
    next_fault = 1'b0;
    al = accumulator_word[7:0];
    ah = accumulator_word[15:8];
    t8 = 8'h00;
    dc = 1'b0;
    prod = 16'h0000;
    cmd_go = wr_fire && widx == `FPU_ADDR_CMD && s_axi_wstrb[0];
    cmd_op = wd[4:0];
    cmd_wide = wd[8];
    popped = (stack_top & `FPU_FLAGS_VALID) | `FPU_FLAGS_RST;
    priv_ok = ~protected_mode || (current_privilege <= io_privilege_field);
    if (cmd_go) begin
      case (cmd_op)
        `FPU_OP_SETC: next_flags[`FPU_F_CARRY] = 1'b1;
        `FPU_OP_CLRC: next_flags[`FPU_F_CARRY] = 1'b0;
        `FPU_OP_INVC: next_flags[`FPU_F_CARRY] = ~flags[`FPU_F_CARRY];
        `FPU_OP_CLRD: next_flags[`FPU_F_DIR] = 1'b0;
        `FPU_OP_SETD: next_flags[`FPU_F_DIR] = 1'b1;
        `FPU_OP_F2H: begin
          // Undefined positions read as zero
          next_acc[15:8] = {flags[`FPU_F_SIGN], flags[`FPU_F_ZERO], 1'b0, flags[`FPU_F_AUX], 1'b0,
                            flags[`FPU_F_PARITY], 1'b0, flags[`FPU_F_CARRY]};
        end
        `FPU_OP_H2F: begin
          next_flags[`FPU_F_SIGN]   = ah[7];
          next_flags[`FPU_F_ZERO]   = ah[6];
          next_flags[`FPU_F_AUX]    = ah[4];
          next_flags[`FPU_F_PARITY] = ah[2];
          next_flags[`FPU_F_CARRY]  = ah[0];
        end
        `FPU_OP_FLAGS_PUSH_OP: next_sp = stack_pointer - `FPU_STACK_STEP;
        `FPU_OP_FLAGS_POP_OP, `FPU_OP_INTERRUPT_RETURN_OP: begin
          next_flags = popped;
          if (protected_mode && current_privilege != 2'b00)
            next_flags[`FPU_F_IO_PRIVILEGE_FIELD_HI:`FPU_F_IO_PRIVILEGE_FIELD_LO] = io_privilege_field;
          if (!priv_ok)
            next_flags[`FPU_F_IE] = flags[`FPU_F_IE];
          next_sp = stack_pointer + `FPU_STACK_STEP;
        end
        `FPU_OP_PADD: begin
          t8 = al;
          dc = flags[`FPU_F_CARRY];
          if (al[3:0] > `FPU_NIB_MAX || flags[`FPU_F_AUX]) begin
            t8 = al + `FPU_DEC_ADJ;
            next_flags[`FPU_F_AUX] = 1'b1;
          end
          if (al > `FPU_PK_MAX || flags[`FPU_F_CARRY]) begin
            t8 = t8 + `FPU_DEC_ADJ_HI;
            dc = 1'b1;
          end
          next_acc[7:0] = t8;
          next_flags[`FPU_F_CARRY] = dc;
        end
        `FPU_OP_PSUB: begin
          t8 = al;
          dc = flags[`FPU_F_CARRY];
          if (al[3:0] > `FPU_NIB_MAX || flags[`FPU_F_AUX]) begin
            t8 = al - `FPU_DEC_ADJ;
            next_flags[`FPU_F_AUX] = 1'b1;
          end
          if (al > `FPU_PK_MAX || flags[`FPU_F_CARRY]) begin
            t8 = t8 - `FPU_DEC_ADJ_HI;
            dc = 1'b1;
          end
          next_acc[7:0] = t8;
          next_flags[`FPU_F_CARRY] = dc;
        end
        `FPU_OP_UADD, `FPU_OP_USUB: begin
          dc = (al[3:0] > `FPU_NIB_MAX) || flags[`FPU_F_AUX];
          t8 = al;
          if (dc) begin
            if (cmd_op == `FPU_OP_UADD) begin
              t8 = al + `FPU_DEC_ADJ;
              next_acc[15:8] = ah + 8'h01;
            end else begin
              t8 = al - `FPU_DEC_ADJ;
              next_acc[15:8] = ah - 8'h01;
            end
          end
          next_acc[7:0] = t8 & `FPU_LOW_NIB;
          next_flags[`FPU_F_CARRY] = dc;
          next_flags[`FPU_F_AUX] = dc;
        end
        `FPU_OP_UMUL: begin
          next_acc[15:8] = al / `FPU_TEN;
          next_acc[7:0]  = al % `FPU_TEN;
        end
        `FPU_OP_UDIV: begin
          prod = ah * `FPU_TEN;
          next_acc[7:0]  = prod[7:0] + al;
          next_acc[15:8] = 8'h00;
        end
        `FPU_OP_MASKI, `FPU_OP_UNMASKI: begin
          if (!priv_ok) next_fault = 1'b1;
          else next_flags[`FPU_F_IE] = (cmd_op == `FPU_OP_UNMASKI);
        end
        `FPU_OP_HALT: begin
          if (protected_mode && current_privilege != 2'b00) next_fault = 1'b1;
        end
        `FPU_OP_LOCK: begin
          if (!priv_ok) next_fault = 1'b1;
        end
        `FPU_OP_IN_IMM, `FPU_OP_IN_REG, `FPU_OP_OUT_IMM, `FPU_OP_OUT_REG: begin
          if (!priv_ok) next_fault = 1'b1;
        end
        default: ;
      endcase
    end
    if (io_read) begin
      if (io_wide) next_acc = io_rdata;
      else next_acc[7:0] = io_rdata[7:0];
    end
  end

  // AXI write channel and state update
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FPU_AXI_OKAY;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data  <= 32'h0000_0000;
      flags <= `FPU_FLAGS_RST;
      accumulator_word <= 16'h0000;
      port_number_register <= 16'h0000;
      stack_pointer <= 16'h0000;
      source_index <= {IDX_W{1'b0}};
      destination_index <= {IDX_W{1'b0}};
      stack_top <= 16'h0000;
      current_privilege <= 2'b00;
      protected_mode <= 1'b0;
      port_imm <= 8'h00;
      lock_pending <= 1'b0;
      io_data <= 16'h0000;
      io_addr <= 16'h0000;
      io_wdata <= 16'h0000;
      io_wide <= 1'b0;
      io_read <= 1'b0;
      io_write <= 1'b0;
      stack_addr <= 16'h0000;
      stack_wdata <= 16'h0000;
      stack_write <= 1'b0;
      bus_lock <= 1'b0;
      halted <= 1'b0;
      protection_fault <= 1'b0;
      irq_take <= 1'b0;
    end else begin
      // Each ready only while its own half is not held keeps payloads simple
      s_axi_awready <= ~aw_held & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
      flags <= next_flags;
      accumulator_word <= next_acc;
      stack_pointer <= next_sp;
      protection_fault <= next_fault;
      io_read <= 1'b0;
      io_write <= 1'b0;
      stack_write <= 1'b0;
      irq_take <= 1'b0;
      if (io_read) io_data <= io_rdata;
      if (aw_held && w_held && !s_axi_bvalid) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (widx > `FPU_ADDR_STKTOP) ? `FPU_AXI_SLVERR : `FPU_AXI_OKAY;
        case (widx)
          `FPU_ADDR_CTRL: begin
            protected_mode <= wd[0];
            current_privilege <= wd[2:1];
          end
          `FPU_ADDR_FLAGS: flags <= wd[15:0];
          `FPU_ADDR_ACCUM: accumulator_word <= wd[15:0];
          `FPU_ADDR_PORT: begin
            port_number_register <= wd[15:0];
            port_imm <= wd[23:16];
          end
          `FPU_ADDR_STACKP: stack_pointer <= wd[15:0];
          `FPU_ADDR_INDEX: begin
            source_index <= wd[IDX_W-1:0];
            destination_index <= wd[IDX_W-1:0];
          end
          `FPU_ADDR_STKTOP: stack_top <= wd[15:0];
          default: ;
        endcase
        if (cmd_go && !next_fault) begin
          // Bus lock holds from the prefix until the next command, which clears it as it executes
          bus_lock <= (cmd_op == `FPU_OP_LOCK);
          case (cmd_op)
            `FPU_OP_FLAGS_PUSH_OP: begin
              stack_addr  <= next_sp;
              stack_wdata <= flags;
              stack_write <= 1'b1;
            end
            `FPU_OP_FLAGS_POP_OP, `FPU_OP_INTERRUPT_RETURN_OP: stack_addr <= stack_pointer;
            `FPU_OP_HALT: halted <= 1'b1;
            `FPU_OP_STRING: begin
              if (flags[`FPU_F_DIR]) begin
                source_index <= source_index - `FPU_STEP;
                destination_index <= destination_index - `FPU_STEP;
              end else begin
                source_index <= source_index + `FPU_STEP;
                destination_index <= destination_index + `FPU_STEP;
              end
            end
            `FPU_OP_IN_IMM, `FPU_OP_IN_REG, `FPU_OP_OUT_IMM, `FPU_OP_OUT_REG: begin
              io_wide <= cmd_wide;
              // Word ports forced even
              io_addr <= ((cmd_op == `FPU_OP_IN_IMM || cmd_op == `FPU_OP_OUT_IMM) ?
                          {8'h00, port_imm} : port_number_register) & {15'h7fff, ~cmd_wide};
              io_wdata <= cmd_wide ? accumulator_word : {8'h00, accumulator_word[7:0]};
              io_read  <= (cmd_op == `FPU_OP_IN_IMM || cmd_op == `FPU_OP_IN_REG);
              io_write <= (cmd_op == `FPU_OP_OUT_IMM || cmd_op == `FPU_OP_OUT_REG);
            end
            default: ;
          endcase
        end else if (cmd_go) begin
          bus_lock <= 1'b0;
        end
      end
      // Interrupt ends halt; maskable only when enabled
      if (irq_nonmaskable || (irq_maskable && flags[`FPU_F_IE])) begin
        irq_take <= 1'b1;
        halted <= 1'b0;
      end
    end
  end

  // AXI read channel
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FPU_AXI_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `FPU_AXI_OKAY;
        case (s_axi_araddr[5:2])
          `FPU_ADDR_CTRL:   s_axi_rdata <= {29'h0, current_privilege, protected_mode};
          `FPU_ADDR_CMD:    s_axi_rdata <= 32'h0000_0000;
          `FPU_ADDR_FLAGS:  s_axi_rdata <= {16'h0000, flags};
          `FPU_ADDR_ACCUM:  s_axi_rdata <= {16'h0000, accumulator_word};
          `FPU_ADDR_PORT:   s_axi_rdata <= {8'h00, port_imm, port_number_register};
          `FPU_ADDR_STACKP: s_axi_rdata <= {16'h0000, stack_pointer};
          `FPU_ADDR_INDEX:  s_axi_rdata <= {destination_index, source_index};
          `FPU_ADDR_STATUS: s_axi_rdata <= {28'h0, protection_fault, bus_lock, halted, lock_pending};
          `FPU_ADDR_STKTOP: s_axi_rdata <= {16'h0000, stack_top};
          `FPU_ADDR_IODATA: s_axi_rdata <= {16'h0000, io_data};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FPU_AXI_SLVERR;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// >>> verif/fpu_port_model.sv
`default_nettype none
module fpu_port_model (
  // Clock
  input wire logic         clock,
  // Peripheral ports
  input wire logic  [15:0] io_addr,
  input wire logic  [15:0] io_wdata,
  input wire logic         io_wide,
  input wire logic         io_read,
  input wire logic         io_write,
  output logic      [15:0] io_rdata,
  // Stack memory
  input wire logic  [15:0] stack_addr,
  input wire logic  [15:0] stack_wdata,
  input wire logic         stack_write
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_data = 16'h0000;
  logic [15:0] rd_addr = 16'h0000, wr_addr = 16'h0000, wr_data = 16'h0000;
  logic [15:0] stk_addr = 16'h0000, stk_data = 16'h0000;
  logic        rd_wide = 1'b0, wr_wide = 1'b0;
  // Idle bus shows the inverse of the last value, so stale data cannot pass
  assign io_rdata = io_read ? (io_addr ^ 16'ha5c3) : ~last_data;
  always @(posedge clock) begin
    if (io_read === 1'b1) begin
      last_data <= io_addr ^ 16'ha5c3;
      rd_addr <= io_addr;
      rd_wide <= io_wide;
    end
    if (io_write === 1'b1) begin
      wr_addr <= io_addr;
      wr_data <= io_wdata;
      wr_wide <= io_wide;
    end
    if (stack_write === 1'b1) begin
      stk_addr <= stack_addr;
      stk_data <= stack_wdata;
    end
  end
endmodule
`default_nettype wire

// >>> verif/fpu_unit_bench.sv
`include "fpu_regs.vh"
`default_nettype none
module fpu_unit_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock = 1'b0;
  logic             reset = 1'b1;
  logic [31:0]      s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic             s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic             s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq_maskable = 1'b0, irq_nonmaskable = 1'b0;
  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic        io_wide, io_read, io_write, stack_write, bus_lock, halted, protection_fault, irq_take;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [15:0] io_addr, io_wdata, io_rdata, stack_addr, stack_wdata;
  int               mismatches = 0, total_checks = 0, n_fault = 0, n_io = 0, n_take = 0;
  always #25 clock = ~clock;
  fpu_unit dut (.clock(clock), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_wide(io_wide), .io_read(io_read), .io_write(io_write), .io_rdata(io_rdata), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata), .stack_write(stack_write), .bus_lock(bus_lock), .halted(halted),
    .protection_fault(protection_fault), .irq_maskable(irq_maskable), .irq_nonmaskable(irq_nonmaskable),
    .irq_take(irq_take));
  fpu_port_model model (.clock(clock), .io_addr(io_addr), .io_wdata(io_wdata), .io_wide(io_wide),
    .io_read(io_read), .io_write(io_write), .io_rdata(io_rdata), .stack_addr(stack_addr),
    .stack_wdata(stack_wdata), .stack_write(stack_write));
  always @(posedge clock) begin
    if (protection_fault === 1'b1) n_fault++;
    if (io_read === 1'b1 || io_write === 1'b1) n_io++;
    if (irq_take === 1'b1) n_take++;
  end
  task automatic close_out;
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up;
    mismatches++;
    $display("wrong value at %0t: no answer", $time);
    close_out();
  endtask
  // Address and data go up together; each is dropped only once taken
  task automatic axi_wr(input logic [3:0] idx, input logic [31:0] data, output logic [1:0] resp);
    int n;
    @(posedge clock);
    s_axi_awaddr <= {26'h0, idx, 2'b00};
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    #1;
  endtask
  task automatic axi_rd(input logic [3:0] idx, output logic [31:0] data, output logic [1:0] resp);
    int n;
    @(posedge clock);
    s_axi_araddr <= {26'h0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (n == 50) give_up();
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [3:0] idx, input logic [31:0] data);
    logic [1:0] r;
    axi_wr(idx, data, r);
    chk(r, `FPU_AXI_OKAY);
  endtask
  task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(idx, d, r);
    chk(d, exp);
  endtask
  task automatic cmd(input logic [4:0] op, input logic wide);
    wr(4'h1, {23'h0, wide, 3'h0, op});
  endtask
  task automatic s_reset;
    logic [31:0] d;
    logic [1:0]  r;
    rd_chk(4'h2, 32'h0002);
    axi_rd(4'hc, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `FPU_AXI_SLVERR});
    axi_wr(4'hc, 32'h1, r);
    chk(r, `FPU_AXI_SLVERR);
  endtask
  task automatic s_carry_dir;
    logic [4:0]  op [6] = '{`FPU_OP_SETC, `FPU_OP_INVC, `FPU_OP_INVC, `FPU_OP_CLRC, `FPU_OP_SETD, `FPU_OP_CLRD};
    logic [15:0] fl [6] = '{16'h0003, 16'h0002, 16'h0003, 16'h0002, 16'h0402, 16'h0002};
    for (int i = 0; i < 6; i++) begin
      cmd(op[i], 1'b0);
      rd_chk(4'h2, {16'h0, fl[i]});
    end
    wr(4'h6, 32'h0010);
    cmd(`FPU_OP_STRING, 1'b0);
    rd_chk(4'h6, 32'h00110011);
    cmd(`FPU_OP_SETD, 1'b0);
    cmd(`FPU_OP_STRING, 1'b0);
    cmd(`FPU_OP_STRING, 1'b0);
    rd_chk(4'h6, 32'h000f000f);
    cmd(`FPU_OP_CLRD, 1'b0);
  endtask
  task automatic s_flags;
    wr(4'h2, 32'h00d5);
    wr(4'h3, 32'h0000);
    cmd(`FPU_OP_F2H, 1'b0);
    rd_chk(4'h3, 32'hd500);
    rd_chk(4'h2, 32'h00d5);
    wr(4'h3, 32'h4400);
    cmd(`FPU_OP_H2F, 1'b0);
    rd_chk(4'h2, 32'h0044);
    wr(4'h5, 32'h0100);
    wr(4'h2, 32'h0403);
    cmd(`FPU_OP_FLAGS_PUSH_OP, 1'b0);
    chk({model.stk_addr, model.stk_data}, 32'h00fe0403);
    rd_chk(4'h5, 32'h00fe);
    rd_chk(4'h2, 32'h0403);
    wr(4'h8, 32'h32c1);
    cmd(`FPU_OP_FLAGS_POP_OP, 1'b0);
    rd_chk(4'h2, 32'h32c3);
    rd_chk(4'h5, 32'h0100);
  endtask
  task automatic s_priv;
    logic [4:0] op [6] = '{`FPU_OP_MASKI, `FPU_OP_UNMASKI, `FPU_OP_HALT, `FPU_OP_LOCK, `FPU_OP_IN_IMM, `FPU_OP_OUT_REG};
    int         f;
    int         io;
    wr(4'h2, 32'h0002);
    wr(4'h0, 32'h0007);
    wr(4'h8, 32'h3201);
    cmd(`FPU_OP_FLAGS_POP_OP, 1'b0);
    rd_chk(4'h2, 32'h0003);
    f = n_fault;
    io = n_io;
    for (int i = 0; i < 6; i++) cmd(op[i], 1'b0);
    chk(n_fault - f, 6);
    chk(n_io - io, 0);
    chk({30'h0, bus_lock, halted}, 32'h0);
    rd_chk(4'h2, 32'h0003);
    wr(4'h0, 32'h0001);
    cmd(`FPU_OP_FLAGS_POP_OP, 1'b0);
    rd_chk(4'h2, 32'h3203);
    wr(4'h0, 32'h0005);
    cmd(`FPU_OP_MASKI, 1'b0);
    rd_chk(4'h2, 32'h3003);
    f = n_fault;
    cmd(`FPU_OP_HALT, 1'b0);
    chk(n_fault - f, 1);
    wr(4'h0, 32'h0000);
    wr(4'h2, 32'h0002);
  endtask
  task automatic s_bcd;
    logic [4:0]  op [8] = '{`FPU_OP_PADD, `FPU_OP_PADD, `FPU_OP_PSUB, `FPU_OP_PSUB, `FPU_OP_UADD, `FPU_OP_USUB,
                            `FPU_OP_UMUL, `FPU_OP_UDIV};
    logic [15:0] ai [8] = '{16'h003c, 16'h009a, 16'h000f, 16'h00ff, 16'h000b, 16'h02ff, 16'h003f, 16'h0407};
    logic [15:0] ao [8] = '{16'h0042, 16'h0000, 16'h0009, 16'h0099, 16'h0101, 16'h0109, 16'h0603, 16'h002f};
    logic [1:0]  cy [8] = '{2'd0, 2'd1, 2'd0, 2'd1, 2'd1, 2'd1, 2'd2, 2'd2};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 8; i++) begin
      wr(4'h2, 32'h0002);
      wr(4'h3, {16'h0, ai[i]});
      cmd(op[i], 1'b0);
      rd_chk(4'h3, {16'h0, ao[i]});
      axi_rd(4'h2, d, r);
      if (cy[i] != 2'd2) chk(d[0], cy[i][0]);
    end
  endtask
  task automatic s_io;
    int io;
    io = n_io;
    wr(4'h4, 32'h00801235);
    wr(4'h3, 32'h7700);
    cmd(`FPU_OP_IN_IMM, 1'b0);
    rd_chk(4'h3, 32'h7743);
    chk({model.rd_addr, 15'h0, model.rd_wide}, 32'h00800000);
    cmd(`FPU_OP_IN_REG, 1'b1);
    rd_chk(4'h3, 32'hb7f7);
    chk({model.rd_addr, 15'h0, model.rd_wide}, 32'h12340001);
    rd_chk(4'h9, 32'hb7f7);
    cmd(`FPU_OP_OUT_IMM, 1'b1);
    chk({model.wr_addr, model.wr_data}, 32'h0080b7f7);
    cmd(`FPU_OP_OUT_REG, 1'b0);
    chk({model.wr_addr, model.wr_data[7:0], 7'h0, model.wr_wide}, 32'h1235f700);
    chk(n_io - io, 4);
  endtask
  task automatic s_lock_halt;
    int t;
    int n;
    cmd(`FPU_OP_LOCK, 1'b0);
    chk(bus_lock, 1'b1);
    cmd(`FPU_OP_CLRC, 1'b0);
    chk(bus_lock, 1'b0);
    cmd(`FPU_OP_HALT, 1'b0);
    t = n_take;
    @(posedge clock);
    irq_maskable <= 1'b1;
    // Masked request must leave the core asleep
    repeat (6) @(posedge clock);
    chk(halted, 1'b1);
    chk(n_take - t, 0);
    irq_nonmaskable <= 1'b1;
    for (n = 0; n < 20 && halted !== 1'b0; n++) @(posedge clock);
    if (n == 20) give_up();
    irq_nonmaskable <= 1'b0;
    chk(halted, 1'b0);
    cmd(`FPU_OP_UNMASKI, 1'b0);
    rd_chk(4'h2, 32'h0202);
    t = n_take;
    repeat (4) @(posedge clock);
    chk(n_take > t, 1'b1);
    irq_maskable <= 1'b0;
    cmd(`FPU_OP_MASKI, 1'b0);
    rd_chk(4'h2, 32'h0002);
  endtask
  initial begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    s_reset();
    s_carry_dir();
    s_flags();
    s_priv();
    s_bcd();
    s_io();
    s_lock_halt();
    close_out();
  end
endmodule
bind fpu_unit fpu_unit_chk u_chk (.clock(clock), .reset(reset), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .io_addr(io_addr), .io_wide(io_wide), .io_read(io_read), .io_write(io_write),
  .stack_write(stack_write), .bus_lock(bus_lock), .halted(halted), .protection_fault(protection_fault),
  .irq_nonmaskable(irq_nonmaskable), .irq_take(irq_take));
`default_nettype wire

// >>> verif/fpu_unit_chk.sv
`default_nettype none
module fpu_unit_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        reset,
  // Bus handshakes
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  // Ports and status
  input wire logic [15:0] io_addr,
  input wire logic        io_wide,
  input wire logic        io_read,
  input wire logic        io_write,
  input wire logic        stack_write,
  input wire logic        bus_lock,
  input wire logic        halted,
  input wire logic        protection_fault,
  input wire logic        irq_nonmaskable,
  input wire logic        irq_take
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  sequence halt_then_take;
    halted ##1 irq_take;
  endsequence
  sequence io_quiet;
    !io_read && !io_write;
  endsequence
  a_fault_pulse: assert property (protection_fault |=> !protection_fault)
    else $error("fault pulse too long");
  a_fault_no_io: assert property (protection_fault |-> io_quiet [*2])
    else $error("port access on fault");
  a_fault_no_stack: assert property (protection_fault |-> !stack_write)
    else $error("stack write on fault");
  a_read_pulse: assert property (io_read |=> !io_read)
    else $error("input pulse too long");
  a_write_pulse: assert property (io_write |=> !io_write)
    else $error("output pulse too long");
  a_wide_even: assert property ((io_read || io_write) && io_wide |-> !io_addr[0])
    else $error("odd word port");
  a_lock_no_fault: assert property ($rose(bus_lock) |-> !protection_fault)
    else $error("lock with fault");
  a_halt_wake: assert property (halt_then_take |-> ##[0:1] !halted)
    else $error("halt not left on interrupt");
  a_nmi_take: assert property (irq_nonmaskable [*2] |-> ##[0:1] irq_take)
    else $error("nonmaskable not taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed");
endmodule
`default_nettype wire
